// file: include/mcrb_pkg.sv
/*
 * Register bank constants: addresses, field positions, reset values and writable masks.
 * Assumes an 8-bit processor bus with a separate special-function space and an
 * external data space.
 */
package mcrb_pkg;
    // =========================================================
    // Special-function space addresses
    localparam logic [7:0] SFA_PORT0_PINS       = 8'h80;
    localparam logic [7:0] SFA_PORT1_PINS       = 8'h90;
    localparam logic [7:0] SFA_PORT1_DIRECTION  = 8'h91;
    localparam logic [7:0] SFA_FLASH_ERASE_CMD  = 8'h94;
    localparam logic [7:0] SFA_EEPROM_BYTE      = 8'h9e;
    localparam logic [7:0] SFA_EEPROM_CONTROL   = 8'h9f;
    localparam logic [7:0] SFA_PORT2_PINS       = 8'ha0;
    localparam logic [7:0] SFA_PORT2_DIRECTION  = 8'ha1;
    localparam logic [7:0] SFA_PORT0_DIRECTION  = 8'ha2;
    localparam logic [7:0] SFA_FLASH_CONTROL    = 8'hb2;
    localparam logic [7:0] SFA_FLASH_PAGE       = 8'hb7;
    localparam logic [7:0] SFA_WDOG_IRQ_ENABLE  = 8'he8;
    localparam logic [7:0] SFA_INTERRUPT_FLAGS  = 8'hf8;
    // =========================================================
    // External 2xxx space addresses
    localparam logic [15:0] XA_CE_CFG           = 16'h2000;
    localparam logic [15:0] XA_CE_CFG2          = 16'h2002;
    localparam logic [15:0] XA_COMPARATOR       = 16'h2003;
    localparam logic [15:0] XA_CHIP_SETUP0      = 16'h2004;
    localparam logic [15:0] XA_CHIP_SETUP1      = 16'h2005;
    localparam logic [15:0] XA_PROBE0           = 16'h2060;
    localparam logic [15:0] XA_PROBE1           = 16'h2061;
    localparam logic [15:0] XA_PROBE2           = 16'h2062;
    localparam logic [15:0] XA_PROBE3           = 16'h2063;
    localparam logic [15:0] XA_SYNC_CTRL        = 16'h2070;
    localparam logic [15:0] XA_SYNC_START       = 16'h2071;
    localparam logic [15:0] XA_SYNC_STOP        = 16'h2072;
    localparam logic [15:0] XA_FUSE_SELECT      = 16'h20fd;
    localparam logic [15:0] XA_FUSE_ADJUST      = 16'h20ff;
    // =========================================================
    // Writable masks; zero positions have no storage and read zero, except in MASK_FLASH_CTRL and MASK_COMP_CFG
    localparam logic [7:0] MASK_FULL            = 8'hff;
    localparam logic [7:0] MASK_PORT2           = 8'h3f;
    localparam logic [7:0] MASK_FLASH_CTRL      = 8'h03;
    localparam logic [7:0] MASK_FLASH_PAGE      = 8'h7f;
    localparam logic [7:0] MASK_WDOG_IRQ        = 8'h83;
    localparam logic [7:0] MASK_INT_FLAGS       = 8'h7f;
    localparam logic [7:0] MASK_COMP_CFG        = 8'h18;
    // =========================================================
    // Field positions
    localparam int COMP_STAT_LSB                = 0;
    localparam int COMP_INT_LSB                 = 3;
    localparam int CHOP_LSB                     = 4;
    localparam int CLKOUT_DIS_BIT               = 4;
    localparam int CONV_DIS_BIT                 = 3;
    localparam int SECURE_BIT                   = 6;
    localparam int PREBOOT_BIT                  = 7;
    localparam logic [1:0] CHOP_ON_CODE         = 2'h3;
    // =========================================================
    // Reset value of every stored bit
    localparam logic [7:0] RESET_VALUE          = 8'h00;
endpackage : mcrb_pkg

// file: logic/mcrb_bank.sv
/*
 * Configuration and status register bank: special-function registers and the
 * 2xxx configuration region, with direct outputs to the controlled units.
 * Assumes one-cycle processor strobes, synchronous to clk, and read data taken
 * one cycle after the read strobe.
 */
`timescale 1ns/1ps
// Function
// R01 - Unused bit positions hold no storage and read back as zero.
// R02 - Software keeps reserved bits at their current value when writing.
// R03 - Every configuration bit clears to zero at power-up unless stated otherwise.
// R04 - Read-only bits ignore processor writes.
// R05 - Frequent controls decode in special-function space, the rest in the 2xxx region.
// R06 - The compute engine takes operating parameters straight from the bank.
// R07 - Setting the converter-disable bit turns the converter and its bias off.
// R08 - Chop select codes 01 and 10 leave chopping off, code 11 turns it on.
// R09 - With the clock-out disable bit at zero the test clock pin is driven.
// R10 - Comparator interrupt select bits enable change interrupts; both set XOR the inputs.
// R11 - Comparator status bits are read-only and mirror comparators one to three.
// R12 - A write takes effect on its completing edge and later reads return it.
module mcrb_bank (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sfs_wr,
    input  wire logic        sfs_rd,
    input  wire logic [7:0]  sfs_addr,
    input  wire logic        xd_wr,
    input  wire logic        xd_rd,
    input  wire logic [15:0] xd_addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [2:0]  comparator_in,
    input  wire logic        preboot_in,
    input  wire logic [6:0]  irq_set,
    output logic      [7:0]  rdata,
    output logic      [7:0]  ce_cfg,
    output logic      [7:0]  ce_cfg2,
    output logic      [7:0]  probe0,
    output logic      [7:0]  probe1,
    output logic      [7:0]  probe2,
    output logic      [7:0]  probe3,
    output logic      [7:0]  sync_serial_ctrl,
    output logic      [7:0]  sync_serial_start,
    output logic      [7:0]  sync_serial_stop,
    output logic      [7:0]  fuse_select,
    output logic      [7:0]  fuse_adjust,
    output logic      [7:0]  chip_setup0,
    output logic      [7:0]  chip_setup1,
    output logic             converter_disable,
    output logic             converter_bias_on,
    output logic             bandgap_chop_on,
    output logic             test_clock_pin_oe,
    output logic             comparator_irq,
    output logic      [7:0]  port0_pins,
    output logic      [7:0]  port1_pins,
    output logic      [7:0]  port2_pins,
    output logic      [7:0]  port0_direction,
    output logic      [7:0]  port1_direction,
    output logic      [7:0]  port2_direction,
    output logic      [7:0]  flash_erase_cmd,
    output logic      [7:0]  serial_eeprom_byte,
    output logic      [7:0]  serial_eeprom_control,
    output logic      [7:0]  flash_control,
    output logic      [7:0]  flash_page_select,
    output logic      [7:0]  watchdog_irq_enable,
    output logic      [7:0]  interrupt_flags
);
    // =========================================================
    // Storage and helpers
    logic [1:0] comp_int_sel;
    logic [2:0] comp_prev;
    logic [2:0] comp_now;
    logic       xor_now;
    logic       xor_prev;
    logic [7:0] next_rdata;

    // Masked write merge; bits outside the mask stay zero
    function automatic logic [7:0] mcrb_merge(input logic [7:0] d, input logic [7:0] m);
        mcrb_merge = d & m;
    endfunction : mcrb_merge

    function automatic logic sfw(input logic [7:0] a, input logic [7:0] target,
                                 input logic we);
        sfw = we && (a == target);
    endfunction : sfw

    function automatic logic xw(input logic [15:0] a, input logic [15:0] target,
                                input logic we);
        xw = we && (a == target);
    endfunction : xw

    // =========================================================
    // Special-function space registers, written on the strobe edge
    always_ff @(posedge clk) begin
        if (srst) begin
            port0_pins            <= mcrb_pkg::RESET_VALUE; // R03
            port1_pins            <= mcrb_pkg::RESET_VALUE;
            port2_pins            <= mcrb_pkg::RESET_VALUE;
            port0_direction       <= mcrb_pkg::RESET_VALUE;
            port1_direction       <= mcrb_pkg::RESET_VALUE;
            port2_direction       <= mcrb_pkg::RESET_VALUE;
            flash_erase_cmd       <= mcrb_pkg::RESET_VALUE;
            serial_eeprom_byte    <= mcrb_pkg::RESET_VALUE;
            serial_eeprom_control <= mcrb_pkg::RESET_VALUE;
            flash_page_select     <= mcrb_pkg::RESET_VALUE;
            watchdog_irq_enable   <= mcrb_pkg::RESET_VALUE;
        end else begin
            // R05 R12
            if (sfw(sfs_addr, mcrb_pkg::SFA_PORT0_PINS, sfs_wr)) begin
                port0_pins <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_PORT1_PINS, sfs_wr)) begin
                port1_pins <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_PORT2_PINS, sfs_wr)) begin
                port2_pins <= mcrb_merge(wdata, mcrb_pkg::MASK_PORT2); // R01
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_PORT0_DIRECTION, sfs_wr)) begin
                port0_direction <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_PORT1_DIRECTION, sfs_wr)) begin
                port1_direction <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_PORT2_DIRECTION, sfs_wr)) begin
                port2_direction <= mcrb_merge(wdata, mcrb_pkg::MASK_PORT2); // R01
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_FLASH_ERASE_CMD, sfs_wr)) begin
                flash_erase_cmd <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_EEPROM_BYTE, sfs_wr)) begin
                serial_eeprom_byte <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_EEPROM_CONTROL, sfs_wr)) begin
                serial_eeprom_control <= wdata;
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_FLASH_PAGE, sfs_wr)) begin
                flash_page_select <= mcrb_merge(wdata, mcrb_pkg::MASK_FLASH_PAGE); // R01
            end
            if (sfw(sfs_addr, mcrb_pkg::SFA_WDOG_IRQ_ENABLE, sfs_wr)) begin
                watchdog_irq_enable <= mcrb_merge(wdata, mcrb_pkg::MASK_WDOG_IRQ); // R01
            end
        end
    end

    // =========================================================
    // Flash control: preboot mirrors hardware, secure only sets until reset
    always_ff @(posedge clk) begin
        if (srst) begin
            flash_control <= mcrb_pkg::RESET_VALUE;
        end else begin
            flash_control[mcrb_pkg::PREBOOT_BIT] <= preboot_in; // R04
            flash_control[5:2] <= 4'h0; // R01
            if (sfw(sfs_addr, mcrb_pkg::SFA_FLASH_CONTROL, sfs_wr)) begin
                flash_control[1:0] <= wdata[1:0];
                // Ones only, so firmware cannot drop protection once taken
                if (wdata[mcrb_pkg::SECURE_BIT]) begin
                    flash_control[mcrb_pkg::SECURE_BIT] <= 1'b1;
                end
            end
        end
    end

    // =========================================================
    // Interrupt flags: hardware set wins over a same-cycle software write
    always_ff @(posedge clk) begin
        if (srst) begin
            interrupt_flags <= mcrb_pkg::RESET_VALUE;
        end else if (sfw(sfs_addr, mcrb_pkg::SFA_INTERRUPT_FLAGS, sfs_wr)) begin
            interrupt_flags <= mcrb_merge(wdata | {1'b0, irq_set}, mcrb_pkg::MASK_INT_FLAGS);
        end else begin
            interrupt_flags <= interrupt_flags | {1'b0, irq_set};
        end
    end

    // =========================================================
    // 2xxx configuration region
    always_ff @(posedge clk) begin
        if (srst) begin
            ce_cfg       <= mcrb_pkg::RESET_VALUE; // R03
            ce_cfg2      <= mcrb_pkg::RESET_VALUE;
            comp_int_sel <= 2'h0;
            chip_setup0  <= mcrb_pkg::RESET_VALUE;
            chip_setup1  <= mcrb_pkg::RESET_VALUE;
            probe0       <= mcrb_pkg::RESET_VALUE;
            probe1       <= mcrb_pkg::RESET_VALUE;
            probe2       <= mcrb_pkg::RESET_VALUE;
            probe3       <= mcrb_pkg::RESET_VALUE;
            sync_serial_ctrl  <= mcrb_pkg::RESET_VALUE;
            sync_serial_start <= mcrb_pkg::RESET_VALUE;
            sync_serial_stop  <= mcrb_pkg::RESET_VALUE;
            fuse_select  <= mcrb_pkg::RESET_VALUE;
            fuse_adjust  <= mcrb_pkg::RESET_VALUE;
        end else begin
            // R05 R12 R06
            if (xw(xd_addr, mcrb_pkg::XA_CE_CFG, xd_wr)) begin
                ce_cfg <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_CE_CFG2, xd_wr)) begin
                ce_cfg2 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_COMPARATOR, xd_wr)) begin
                comp_int_sel <= wdata[mcrb_pkg::COMP_INT_LSB +: 2]; // R04
            end
            if (xw(xd_addr, mcrb_pkg::XA_CHIP_SETUP0, xd_wr)) begin
                chip_setup0 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_CHIP_SETUP1, xd_wr)) begin
                chip_setup1 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_PROBE0, xd_wr)) begin
                probe0 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_PROBE1, xd_wr)) begin
                probe1 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_PROBE2, xd_wr)) begin
                probe2 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_PROBE3, xd_wr)) begin
                probe3 <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_SYNC_CTRL, xd_wr)) begin
                sync_serial_ctrl <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_SYNC_START, xd_wr)) begin
                sync_serial_start <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_SYNC_STOP, xd_wr)) begin
                sync_serial_stop <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_FUSE_SELECT, xd_wr)) begin
                fuse_select <= wdata;
            end
            if (xw(xd_addr, mcrb_pkg::XA_FUSE_ADJUST, xd_wr)) begin
                fuse_adjust <= wdata;
            end
        end
    end

    // =========================================================
    // Analog controls decoded from the stored bits, one cycle behind the write
    always_ff @(posedge clk) begin
        if (srst) begin
            converter_disable <= 1'b0;
            converter_bias_on <= 1'b0;
            bandgap_chop_on   <= 1'b0;
            test_clock_pin_oe <= 1'b0;
        end else begin
            converter_disable <= chip_setup1[mcrb_pkg::CONV_DIS_BIT]; // R07
            converter_bias_on <= ~chip_setup1[mcrb_pkg::CONV_DIS_BIT]; // R07
            bandgap_chop_on   <= (ce_cfg2[mcrb_pkg::CHOP_LSB +: 2]
                                  == mcrb_pkg::CHOP_ON_CODE); // R08
            test_clock_pin_oe <= ~chip_setup0[mcrb_pkg::CLKOUT_DIS_BIT]; // R09
        end
    end

    // =========================================================
    // Comparator change detection; inputs are synchronous, so no synchroniser
    always_comb begin
        comp_now = comparator_in;
        xor_now  = comparator_in[1] ^ comparator_in[2];
        xor_prev = comp_prev[1] ^ comp_prev[2];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            comp_prev      <= 3'h0;
            comparator_irq <= 1'b0;
        end else begin
            comp_prev <= comp_now; // R11
            // Select bit 0 watches comparator two, bit 1 comparator three; both set XOR them
            if (comp_int_sel == 2'h3) begin
                comparator_irq <= (xor_now != xor_prev); // R10
            end else begin
                comparator_irq <= (comp_int_sel[0] && (comp_now[1] != comp_prev[1]))
                               || (comp_int_sel[1] && (comp_now[2] != comp_prev[2])); // R10
            end
        end
    end

    // =========================================================
    // Read multiplexer; unmapped addresses and unused bits read zero
    always_comb begin
        next_rdata = 8'h00;
        if (sfs_rd) begin
            case (sfs_addr)
                mcrb_pkg::SFA_PORT0_PINS:      next_rdata = port0_pins;
                mcrb_pkg::SFA_PORT1_PINS:      next_rdata = port1_pins;
                mcrb_pkg::SFA_PORT1_DIRECTION: next_rdata = port1_direction;
                mcrb_pkg::SFA_FLASH_ERASE_CMD: next_rdata = flash_erase_cmd;
                mcrb_pkg::SFA_EEPROM_BYTE:     next_rdata = serial_eeprom_byte;
                mcrb_pkg::SFA_EEPROM_CONTROL:  next_rdata = serial_eeprom_control;
                mcrb_pkg::SFA_PORT2_PINS:      next_rdata = port2_pins;
                mcrb_pkg::SFA_PORT2_DIRECTION: next_rdata = port2_direction;
                mcrb_pkg::SFA_PORT0_DIRECTION: next_rdata = port0_direction;
                mcrb_pkg::SFA_FLASH_CONTROL:   next_rdata = flash_control;
                mcrb_pkg::SFA_FLASH_PAGE:      next_rdata = flash_page_select;
                mcrb_pkg::SFA_WDOG_IRQ_ENABLE: next_rdata = watchdog_irq_enable;
                mcrb_pkg::SFA_INTERRUPT_FLAGS: next_rdata = interrupt_flags;
                default:                       next_rdata = 8'h00; // R01
            endcase
        end else if (xd_rd) begin
            case (xd_addr)
                mcrb_pkg::XA_CE_CFG:      next_rdata = ce_cfg;
                mcrb_pkg::XA_CE_CFG2:     next_rdata = ce_cfg2;
                mcrb_pkg::XA_COMPARATOR:  next_rdata = {3'h0, comp_int_sel, comparator_in}; // R11
                mcrb_pkg::XA_CHIP_SETUP0: next_rdata = chip_setup0;
                mcrb_pkg::XA_CHIP_SETUP1: next_rdata = chip_setup1;
                mcrb_pkg::XA_PROBE0:      next_rdata = probe0;
                mcrb_pkg::XA_PROBE1:      next_rdata = probe1;
                mcrb_pkg::XA_PROBE2:      next_rdata = probe2;
                mcrb_pkg::XA_PROBE3:      next_rdata = probe3;
                mcrb_pkg::XA_SYNC_CTRL:   next_rdata = sync_serial_ctrl;
                mcrb_pkg::XA_SYNC_START:  next_rdata = sync_serial_start;
                mcrb_pkg::XA_SYNC_STOP:   next_rdata = sync_serial_stop;
                mcrb_pkg::XA_FUSE_SELECT: next_rdata = fuse_select;
                mcrb_pkg::XA_FUSE_ADJUST: next_rdata = fuse_adjust;
                default:                  next_rdata = 8'h00; // R01
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // =========================================================
    // Checks
    sequence s_x_write(logic [15:0] a);
        xd_wr && (xd_addr == a);
    endsequence

    AST_WRITE_LANDS: assert property (@(posedge clk) disable iff (srst) // R12
        s_x_write(mcrb_pkg::XA_PROBE0) |=> (probe0 == $past(wdata)))
        else $error("probe write not stored");
    AST_CONV_OFF: assert property (@(posedge clk) disable iff (srst) // R07
        chip_setup1[mcrb_pkg::CONV_DIS_BIT] |=> (converter_disable && !converter_bias_on))
        else $error("converter not disabled");
    AST_CHOP: assert property (@(posedge clk) disable iff (srst) // R08
        ##1 (bandgap_chop_on == ($past(ce_cfg2[5:4]) == 2'h3)))
        else $error("chop decode wrong");
    AST_CLKOUT: assert property (@(posedge clk) disable iff (srst) // R09
        !chip_setup0[mcrb_pkg::CLKOUT_DIS_BIT] |=> test_clock_pin_oe)
        else $error("test clock not driven");
    AST_COMP_MASK: assert property (@(posedge clk) disable iff (srst) // R10
        (comp_int_sel == 2'h0) |=> !comparator_irq)
        else $error("masked comparator interrupt");
    AST_COMP_STAT: assert property (@(posedge clk) disable iff (srst) // R11
        xd_rd && (xd_addr == mcrb_pkg::XA_COMPARATOR) |=> (rdata[2:0] == $past(comparator_in)))
        else $error("comparator status wrong");
    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (srst) // R01
        ##1 (port2_direction[7:6] == 2'h0 && interrupt_flags[7] == 1'b0))
        else $error("unused bit stored");
    AST_PREBOOT_RO: assert property (@(posedge clk) disable iff (srst) // R04
        ##1 (flash_control[mcrb_pkg::PREBOOT_BIT] == $past(preboot_in)))
        else $error("preboot bit written");
    AST_RESET_CLEAR: assert property (@(posedge clk) // R03
        srst |=> (ce_cfg == 8'h00 && chip_setup0 == 8'h00 && port0_pins == 8'h00))
        else $error("reset value wrong");
endmodule : mcrb_bank

// file: tb/mcrb_cpu_model.sv
/* Processor bus model: byte reads and writes on the special-function and 2xxx strobes.
   Assumes the bank samples strobes on the rising edge and answers reads one cycle later. */
`timescale 1ns/1ps
// ==========
// Bus master
module mcrb_cpu_model (
    input  wire logic        clk,
    input  wire logic [7:0]  rdata,
    output logic             sfs_wr,
    output logic             sfs_rd,
    output logic [7:0]       sfs_addr,
    output logic             xd_wr,
    output logic             xd_rd,
    output logic [15:0]      xd_addr,
    output logic [7:0]       wdata
);
    initial {sfs_wr, sfs_rd, xd_wr, xd_rd, sfs_addr, xd_addr, wdata} = '0;
    // One access, held across one rising edge; idle lines show the inverse, not stale data
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        {sfs_addr, xd_addr, wdata} = {a[7:0], a, d};
        {sfs_wr, sfs_rd, xd_wr, xd_rd} = (a[15:8] == 8'h00) ? {wr, !wr, 2'b00} : {2'b00, wr, !wr};
        @(negedge clk);
        q = rdata;
        {sfs_wr, sfs_rd, xd_wr, xd_rd} = 4'h0;
        {sfs_addr, xd_addr, wdata} = ~{a[7:0], a, d};
    endtask : acc
    // Field update that keeps every other bit, reserved ones included
    task automatic rmw(input logic [15:0] a, input logic [7:0] m, input logic [7:0] v);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        acc(1'b1, a, (q & ~m) | (v & m), q);
    endtask : rmw
endmodule : mcrb_cpu_model

// file: tb/test_meter_config_register_bank.sv
/* Self-checking bench for the register bank: reset values, masks, decodes, comparator.
   Assumes the bus model above drives every processor strobe. */
`timescale 1ns/1ps
module test_meter_config_register_bank;
    logic       clk = 1'b0, srst = 1'b1, preboot_in = 1'b0;
    logic [2:0] comparator_in = 3'h0;
    logic [6:0] irq_set = 7'h00;
    logic       sfs_wr, sfs_rd, xd_wr, xd_rd, converter_disable, converter_bias_on;
    logic       bandgap_chop_on, test_clock_pin_oe, comparator_irq;
    logic [7:0] sfs_addr, wdata, rdata, ce_cfg, ce_cfg2, probe0, probe1, probe2, probe3;
    logic [7:0] sync_serial_ctrl, sync_serial_start, sync_serial_stop, fuse_select, fuse_adjust;
    logic [7:0] chip_setup0, chip_setup1, port0_pins, port1_pins, port2_pins, port0_direction;
    logic [7:0] port1_direction, port2_direction, flash_erase_cmd, serial_eeprom_byte;
    logic [7:0] serial_eeprom_control, flash_control, flash_page_select, watchdog_irq_enable;
    logic [7:0] interrupt_flags, q, d, cnt;
    logic [15:0] xd_addr;
    logic [15:0] regs [27] = '{16'h80, 16'h90, 16'h91, 16'h94, 16'h9e, 16'h9f, 16'ha0,
        16'ha1, 16'ha2, 16'hb7, 16'he8, 16'hf8, 16'h2000, 16'h2002, 16'h2060, 16'h2061,
        16'h2062, 16'h2063, 16'h2070, 16'h2071, 16'h2072, 16'h20fd, 16'h20ff, 16'hb2,
        16'h2003, 16'h2004, 16'h2005};
    logic [15:0] bad [4] = '{16'h2001, 16'h2006, 16'h0081, 16'h00ff};
    logic [1:0]  sels [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
    int seed = 59, n_tests = 0, miscompares = 0;
    // Output ports in the order of the first 23 addresses above, first one on top
    wire [183:0] outs = {port0_pins, port1_pins, port1_direction, flash_erase_cmd,
        serial_eeprom_byte, serial_eeprom_control, port2_pins, port2_direction,
        port0_direction, flash_page_select, watchdog_irq_enable, interrupt_flags, ce_cfg,
        ce_cfg2, probe0, probe1, probe2, probe3, sync_serial_ctrl, sync_serial_start,
        sync_serial_stop, fuse_select, fuse_adjust};

    mcrb_bank dut_u (.*);
    mcrb_cpu_model cpu_u (.*);

    always #4 clk = ~clk;
    // ==========
    // Expectations
    // Stored bits per address; zero marks places that the random pass leaves alone
    function automatic logic [7:0] mask_of(input logic [15:0] a);
        case (a)
            16'h00a0, 16'h00a1: mask_of = mcrb_pkg::MASK_PORT2;
            16'h00b7: mask_of = mcrb_pkg::MASK_FLASH_PAGE;
            16'h00e8: mask_of = mcrb_pkg::MASK_WDOG_IRQ;
            16'h00f8: mask_of = mcrb_pkg::MASK_INT_FLAGS;
            16'h00b2, 16'h2003, 16'h2004, 16'h2005: mask_of = 8'h00;
            default: mask_of = mcrb_pkg::MASK_FULL;
        endcase
    endfunction : mask_of
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Hang guard; the whole sequence needs far fewer cycles
    initial begin
        #400000;
        miscompares++;
        complete_run();
    end
    // ==========
    // Sequence
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        foreach (regs[i]) begin
            cpu_u.acc(1'b0, regs[i], 8'h00, q);
            chk(q, 8'h00);
        end
        chk({converter_bias_on, test_clock_pin_oe, bandgap_chop_on, converter_disable}, 8'h0c);
        // Random bytes; unused bits must come back zero
        repeat (3) foreach (regs[i]) if (mask_of(regs[i]) != 8'h00) begin
            d = 8'($random(seed));
            cpu_u.acc(1'b1, regs[i], d, q);
            cpu_u.acc(1'b0, regs[i], 8'h00, q);
            chk(q, d & mask_of(regs[i]));
            chk(outs[(22 - i) * 8 +: 8], d & mask_of(regs[i]));
        end
        cpu_u.acc(1'b1, 16'h2000, 8'h5a, q);
        chk(ce_cfg, 8'h5a);
        foreach (bad[i]) begin
            cpu_u.acc(1'b1, bad[i], 8'hff, q);
            cpu_u.acc(1'b0, bad[i], 8'h00, q);
            chk(q, 8'h00);
        end
        // Status bits follow the pins and shrug off writes
        for (int k = 0; k < 8; k++) begin
            comparator_in = k[2:0];
            cpu_u.acc(1'b1, 16'h2003, 8'hff, q);
            cpu_u.acc(1'b0, 16'h2003, 8'h00, q);
            chk(q, {3'b000, 2'b11, k[2:0]});
        end
        foreach (sels[i]) begin
            cpu_u.acc(1'b1, 16'h2003, {3'b000, sels[i], 3'b000}, q);
            repeat (3) @(negedge clk);
            // Single selects toggle only their own comparator; 11 toggles one XOR input
            comparator_in = (sels[i] == 2'b00) ? ~comparator_in
                          : comparator_in ^ ((sels[i] == 2'b11) ? 3'h2 : {sels[i], 1'b0});
            cnt = 8'h00;
            repeat (4) @(negedge clk) cnt += comparator_irq;
            chk(cnt, {7'h00, sels[i] != 2'b00});
        end
        // Every chop code, with converter and clock-out bits walked alongside
        for (int c = 0; c < 4; c++) begin
            cpu_u.rmw(16'h2002, 8'h30, c[7:0] << 4);
            cpu_u.rmw(16'h2005, 8'h08, {4'h0, c[0], 3'h0});
            cpu_u.rmw(16'h2004, 8'h10, {3'h0, c[1], 4'h0});
            repeat (2) @(negedge clk);
            chk(bandgap_chop_on, {7'h00, c == 3});
            chk({converter_disable, converter_bias_on}, {6'h00, c[0], !c[0]});
            chk(test_clock_pin_oe, {7'h00, !c[1]});
            chk(chip_setup1 & 8'h08, {4'h0, c[0], 3'h0});
            chk(chip_setup0 & 8'h10, {3'h0, c[1], 4'h0});
        end
        // Security bit sticks at one; boot status follows its input
        preboot_in = 1'b1;
        cpu_u.acc(1'b1, 16'h00b2, 8'h43, q);
        cpu_u.acc(1'b1, 16'h00b2, 8'h00, q);
        cpu_u.acc(1'b0, 16'h00b2, 8'h00, q);
        chk(q, 8'hc0);
        chk(flash_control, 8'hc0);
        // A hardware flag raised across a clearing write stays set
        irq_set = 7'h02;
        cpu_u.acc(1'b1, 16'h00f8, 8'h00, q);
        irq_set = 7'h00;
        cpu_u.acc(1'b0, 16'h00f8, 8'h00, q);
        chk(q, 8'h02);
        complete_run();
    end
endmodule : test_meter_config_register_bank
